/* File: hw/svac_search.sv */
// band search engine: steps oscillator bands until the tune code has margin or all bands are tried
`timescale 1ns/1ps
`include "svac_map.svh"
module svac_search (
  input  wire logic    mclk,
  input  wire logic    nrst,
  svac_srch_if.engine  sif
);
  localparam logic [7:0] SETTLE_CYC = 8'(`SVAC_SETTLE_CYC);
  localparam logic [4:0] LAST_BAND  = 5'(`SVAC_BAND_COUNT - 1);
  svac_pkg::svac_state_t state, next_state;
  svac_pkg::svac_band_t  band, next_band, first, next_first;
  logic [7:0]            cnt, next_cnt;
  logic [4:0]            tries, next_tries;
  logic                  done, next_done, found, next_found;
  // ---------------------------------------------------------------
  // search sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_band  = band;
    next_first = first;
    next_cnt   = cnt;
    next_tries = tries;
    next_done  = 1'b0;
    next_found = found;
    if (sif.start) begin
      // restart from the manual band, band 0 when it is out of range
      next_first = (sif.first_band > LAST_BAND) ? 5'h00 : sif.first_band; // [R11]
      next_band  = next_first; // [R11]
      next_tries = 5'h00;
      next_cnt   = SETTLE_CYC;
      next_state = svac_pkg::SV_SETTLE;
    end else begin
      unique case (state)
        svac_pkg::SV_IDLE: begin
        end
        svac_pkg::SV_SETTLE: begin
          next_cnt = cnt - 8'h01;
          if (cnt == 8'h01) next_state = svac_pkg::SV_JUDGE;
        end
        svac_pkg::SV_JUDGE: begin
          if (svac_pkg::svac_margin(sif.code)) begin // [R16]
            next_done  = 1'b1; // [R17]
            next_found = 1'b1;
            next_state = svac_pkg::SV_IDLE;
          end else if (tries == LAST_BAND) begin
            next_done  = 1'b1;
            next_found = 1'b0;
            next_band  = first;
            next_state = svac_pkg::SV_IDLE;
          end else begin
            next_band  = (band == LAST_BAND) ? 5'h00 : band + 5'h01;
            next_tries = tries + 5'h01;
            next_cnt   = SETTLE_CYC;
            next_state = svac_pkg::SV_SETTLE;
          end
        end
        default: next_state = svac_pkg::SV_IDLE; // unused state code falls back to idle
      endcase
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= svac_pkg::SV_IDLE;
      band  <= `SVAC_RST_BAND;
      first <= `SVAC_RST_BAND;
      cnt   <= 8'h00;
      tries <= 5'h00;
      done  <= 1'b0;
      found <= 1'b0;
    end else begin
      state <= next_state;
      band  <= next_band;
      first <= next_first;
      cnt   <= next_cnt;
      tries <= next_tries;
      done  <= next_done;
      found <= next_found;
    end
  end
  // outputs to the register side
  assign sif.band  = band;
  assign sif.busy  = (state != svac_pkg::SV_IDLE);
  assign sif.done  = done;
  assign sif.found = found;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_first_band: assert property (@(posedge mclk) disable iff (!nrst) // [R11]
    sif.start && sif.first_band <= LAST_BAND |=> band == $past(sif.first_band))
    else $error("search did not begin at manual band");
  a_accept_margin: assert property (@(posedge mclk) disable iff (!nrst) // [R17]
    done && found |-> svac_pkg::svac_margin($past(sif.code)))
    else $error("band accepted without margin code");
  c_search_found: cover property (@(posedge mclk) disable iff (!nrst) done && found);
  c_search_fail:  cover property (@(posedge mclk) disable iff (!nrst) done && !found);
endmodule

/* File: hw/svac_top.sv */
// synthesizer control: divider registers, band search control, tune converter readback
// Behaviour
// R1: gain code 0..15 maps to 0..15 dB baseband gain, 1 dB per step.
// R2: integer and fractional dividers are plain unsigned, integer split 14:8 and 7:0.
// R3: host forms fractional word as fraction times two to twenty, rounded up.
// R4: host picks reference divider giving comparison frequency 12 to 30 MHz.
// R5: host rewrites all divider registers on every LO change.
// R6: twenty four bands, manually chosen by the five bit band field.
// R7: second status byte shows the band in use, manual or searched.
// R8: with auto search enabled the band is chosen by the search.
// R9: a completed write to fractional LSB register starts the search.
// R10: host writes fractional LSB register after all other PLL settings.
// R11: search starts from the manual band field.
// R12: search-ended flag reads zero while the search runs.
// R13: on success both flags set and chosen band is shown.
// R14: on failure success flag clears and ended flag sets.
// R15: three bit tune voltage code serves as lock indicator.
// R16: codes 0/7 unlocked, 1/6 locked, 2/5 locked with margin.
// R17: search only accepts a band with a margin code.
// R18: converter runs when enabled; reading captured on later latch write.
// R19: standby bit shuts the signal path, bus and reference stay on.
// R20: register contents persist through standby.
// R21: host programs all registers no sooner than 100 us after power-up.
// R22: status byte two holds band in 7:3, converter code in 2:0.
// R23: fractional LSB write with auto search off leaves search flags alone.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "svac_map.svh"
module svac_top (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  tune_code_in,
  output logic             tune_converter_on,
  output logic      [4:0]  band_active,
  output logic      [14:0] n_divider,
  output logic      [19:0] f_divider,
  output logic      [4:0]  ref_divider,
  output logic             lo_divide_select,
  output logic             pump_current_auto,
  output logic      [1:0]  pump_current_level,
  output logic      [3:0]  baseband_gain_db,
  output logic             signal_path_on
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [3:0] baseband_gain_code, next_gain;
  logic       standby_request, next_standby_request;
  logic [6:0] n_hi, next_n_hi;
  logic [7:0] n_lo, next_n_lo;
  logic [3:0] f_hi, next_f_hi;
  logic [7:0] f_mid, next_f_mid, f_lsb, next_f_lsb;
  logic [4:0] ref_div, next_ref_div;
  logic [3:0] pump, next_pump;
  svac_pkg::svac_band_t band_select, next_band_sel;
  logic       auto_band_search_enable, next_auto;
  logic       tune_converter_enable, next_conv;
  logic       search_ended_flag, next_ended;
  logic       search_success_flag, next_ok;
  svac_pkg::svac_code_t conv_held, next_conv_held;
  logic [31:0] rdata, next_rdata;
  logic [5:0]  idx;
  logic        mapped, ro_reg, wr, start_search, latch_hit;
  svac_srch_if sif ();
  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign idx    = paddr[7:2];
  assign ro_reg = (idx == `SVAC_IDX_STAT1) || (idx == `SVAC_IDX_STAT2);
  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      unique case (idx)
        `SVAC_IDX_CTRL, `SVAC_IDX_NHI, `SVAC_IDX_NLO, `SVAC_IDX_FHI,
        `SVAC_IDX_FMID, `SVAC_IDX_FLSB, `SVAC_IDX_REFDIV, `SVAC_IDX_PUMP,
        `SVAC_IDX_OSC, `SVAC_IDX_STAT1, `SVAC_IDX_STAT2: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end
  // zero wait states; error on unmapped address or write to status
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && ro_reg));
  assign wr      = psel && penable && pwrite && mapped && !ro_reg;
  assign prdata  = rdata;
  // search starts only on the LSB write with auto selection on
  assign start_search = wr && (idx == `SVAC_IDX_FLSB) && auto_band_search_enable; // [R9] [R23]
  // latch write captures only when converter was already enabled
  assign latch_hit = wr && (idx == `SVAC_IDX_OSC) && pwdata[`SVAC_OSC_LATCH]
                     && tune_converter_enable; // [R18]
  // ---------------------------------------------------------------
  // next register values
  // ---------------------------------------------------------------
  always_comb begin
    next_gain      = baseband_gain_code;
    next_standby_request      = standby_request;
    next_n_hi      = n_hi;
    next_n_lo      = n_lo;
    next_f_hi      = f_hi;
    next_f_mid     = f_mid;
    next_f_lsb     = f_lsb;
    next_ref_div   = ref_div;
    next_pump      = pump;
    next_band_sel  = band_select;
    next_auto      = auto_band_search_enable;
    next_conv      = tune_converter_enable;
    next_conv_held = conv_held;
    next_ended     = search_ended_flag;
    next_ok        = search_success_flag;
    if (wr) begin
      unique case (idx)
        `SVAC_IDX_CTRL: begin
          next_gain = pwdata[3:0];
          next_standby_request = pwdata[`SVAC_CTRL_STANDBY_REQUEST];
        end
        `SVAC_IDX_NHI:    next_n_hi    = pwdata[6:0]; // [R2]
        `SVAC_IDX_NLO:    next_n_lo    = pwdata[7:0]; // [R2]
        `SVAC_IDX_FHI:    next_f_hi    = pwdata[3:0];
        `SVAC_IDX_FMID:   next_f_mid   = pwdata[7:0];
        `SVAC_IDX_FLSB:   next_f_lsb   = pwdata[7:0];
        `SVAC_IDX_REFDIV: next_ref_div = pwdata[4:0];
        `SVAC_IDX_PUMP:   next_pump    = pwdata[3:0];
        `SVAC_IDX_OSC: begin
          next_band_sel = pwdata[7:3]; // [R6]
          next_auto     = pwdata[`SVAC_OSC_AUTO];
          next_conv     = pwdata[`SVAC_OSC_CONV];
        end
        default: begin
        end
      endcase
    end
    if (latch_hit) next_conv_held = tune_code_in; // [R18]
    // search end wins unless a fresh search starts in the same cycle
    if (sif.done) begin
      next_ended = 1'b1; // [R13] [R14]
      next_ok    = sif.found; // [R13] [R14]
    end
    if (start_search) next_ended = 1'b0; // [R12]
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      baseband_gain_code      <= 4'h0;
      standby_request         <= 1'b0;
      n_hi                    <= 7'h00;
      n_lo                    <= 8'h00;
      f_hi                    <= 4'h0;
      f_mid                   <= 8'h00;
      f_lsb                   <= 8'h00;
      ref_div                 <= `SVAC_RST_REFDIV;
      pump                    <= 4'h0;
      band_select             <= `SVAC_RST_BAND;
      auto_band_search_enable <= 1'b0;
      tune_converter_enable   <= 1'b0;
      conv_held               <= 3'h0;
      search_ended_flag       <= `SVAC_RST_ENDED;
      search_success_flag     <= 1'b0;
    end else begin
      baseband_gain_code      <= next_gain;
      standby_request         <= next_standby_request;
      n_hi                    <= next_n_hi;
      n_lo                    <= next_n_lo;
      f_hi                    <= next_f_hi;
      f_mid                   <= next_f_mid;
      f_lsb                   <= next_f_lsb;
      ref_div                 <= next_ref_div;
      pump                    <= next_pump;
      band_select             <= next_band_sel;
      auto_band_search_enable <= next_auto;
      tune_converter_enable   <= next_conv;
      conv_held               <= next_conv_held;
      search_ended_flag       <= next_ended;
      search_success_flag     <= next_ok;
    end
  end
  // ---------------------------------------------------------------
  // read data, captured in the setup cycle
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = rdata;
    if (psel && !penable) begin
      next_rdata = 32'h0000_0000;
      unique case (idx)
        `SVAC_IDX_CTRL:   next_rdata[7:0] = {standby_request, 3'h0, baseband_gain_code};
        `SVAC_IDX_NHI:    next_rdata[6:0] = n_hi;
        `SVAC_IDX_NLO:    next_rdata[7:0] = n_lo;
        `SVAC_IDX_FHI:    next_rdata[3:0] = f_hi;
        `SVAC_IDX_FMID:   next_rdata[7:0] = f_mid;
        `SVAC_IDX_FLSB:   next_rdata[7:0] = f_lsb;
        `SVAC_IDX_REFDIV: next_rdata[4:0] = ref_div;
        `SVAC_IDX_PUMP:   next_rdata[3:0] = pump;
        `SVAC_IDX_OSC:    next_rdata[7:0] = {band_select, auto_band_search_enable,
                                             tune_converter_enable, 1'b0};
        `SVAC_IDX_STAT1:  next_rdata[1:0] = {search_ended_flag, search_success_flag};
        `SVAC_IDX_STAT2:  next_rdata[7:0] = {band_active, conv_held}; // [R7] [R22] [R15]
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rdata <= 32'h0000_0000;
    else       rdata <= next_rdata;
  end
  // ---------------------------------------------------------------
  // search engine and outputs
  // ---------------------------------------------------------------
  assign sif.start      = start_search;
  assign sif.first_band = band_select; // [R11]
  assign sif.code       = tune_code_in;
  svac_search u_search (
    .mclk (mclk),
    .nrst (nrst),
    .sif  (sif)
  );
  // band in use: searched when auto on, else manual
  assign band_active        = auto_band_search_enable ? sif.band : band_select; // [R8] [R7]
  assign n_divider          = {n_hi, n_lo}; // [R2]
  assign f_divider          = {f_hi, f_mid, f_lsb};
  assign ref_divider        = ref_div;
  assign lo_divide_select   = pump[`SVAC_PUMP_DIV];
  assign pump_current_auto  = pump[`SVAC_PUMP_AUTO];
  assign pump_current_level = pump[1:0];
  // one code step is one dB of baseband gain
  assign baseband_gain_db   = 4'(baseband_gain_code * `SVAC_GAIN_STEP_DB); // [R1]
  // standby gates only the signal path; registers are untouched
  assign signal_path_on     = !standby_request; // [R19] [R20]
  assign tune_converter_on  = tune_converter_enable; // [R18]
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_start_clears_ended: assert property (start_search |=> !search_ended_flag) // [R12]
    else $error("ended flag not cleared at search start");
  a_busy_holds_ended: assert property (sif.busy && !sif.done |=> !search_ended_flag) // [R12]
    else $error("ended flag set while search runs");
  a_done_sets_flags: assert property (sif.done && !start_search // [R13]
    |=> search_ended_flag && search_success_flag == $past(sif.found))
    else $error("flags wrong at search end");
  a_fail_clears_ok: assert property (sif.done && !sif.found && !start_search // [R14]
    |=> !search_success_flag)
    else $error("success flag kept after failed search");
  a_no_start_manual: assert property (wr && idx == `SVAC_IDX_FLSB // [R23]
    && !auto_band_search_enable |=> $stable(search_ended_flag) || $past(sif.done))
    else $error("flags moved on lsb write with auto off");
  a_latch_capture: assert property (latch_hit |=> conv_held == $past(tune_code_in)) // [R18]
    else $error("converter code not latched");
  a_latch_needs_en: assert property (!tune_converter_enable |=> $stable(conv_held)) // [R18]
    else $error("converter code changed while disabled");
  a_manual_band: assert property (!auto_band_search_enable |-> band_active == band_select) // [R7]
    else $error("manual band not reported");
  a_standby_path: assert property (wr && idx == `SVAC_IDX_CTRL // [R19]
    |=> signal_path_on == !$past(pwdata[`SVAC_CTRL_STANDBY_REQUEST]))
    else $error("standby did not follow control write");
  a_gain_map: assert property (wr && idx == `SVAC_IDX_CTRL // [R1]
    |=> baseband_gain_db == $past(pwdata[3:0]))
    else $error("gain not one dB per code");
  c_auto_search: cover property (start_search ##[1:1000] sif.done);
  c_latch:       cover property (latch_hit);
  c_standby:     cover property (!signal_path_on);
endmodule

/* File: include/svac_map.svh */
// register indices, field positions, reset values and timing of the synthesizer control
`ifndef SVAC_MAP_SVH
`define SVAC_MAP_SVH
// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define SVAC_IDX_CTRL    6'h00
`define SVAC_IDX_NHI     6'h01
`define SVAC_IDX_NLO     6'h02
`define SVAC_IDX_FHI     6'h03
`define SVAC_IDX_FMID    6'h04
`define SVAC_IDX_FLSB    6'h05
`define SVAC_IDX_REFDIV  6'h06
`define SVAC_IDX_PUMP    6'h07
`define SVAC_IDX_OSC     6'h08
`define SVAC_IDX_STAT1   6'h0C
`define SVAC_IDX_STAT2   6'h0D
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SVAC_CTRL_STANDBY_REQUEST   7
`define SVAC_OSC_AUTO    2
`define SVAC_OSC_CONV    1
`define SVAC_OSC_LATCH   0
`define SVAC_PUMP_DIV    3
`define SVAC_PUMP_AUTO   2
`define SVAC_ST1_ENDED   1
`define SVAC_ST1_OK      0
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SVAC_RST_REFDIV  5'h01
`define SVAC_RST_BAND    5'h00
`define SVAC_RST_ENDED   1'b1
// ---------------------------------------------------------------
// timing and ranges
// ---------------------------------------------------------------
`define SVAC_CLK_NS      5
`define SVAC_SETTLE_NS   1000
`define SVAC_SETTLE_CYC  ((`SVAC_SETTLE_NS + `SVAC_CLK_NS - 1) / `SVAC_CLK_NS)
`define SVAC_BAND_COUNT  24
`define SVAC_GAIN_STEP_DB 1
`define SVAC_GAIN_SPAN_DB 15
`endif

/* File: include/svac_pkg.sv */
// types shared by the synthesizer control and its band search engine
package svac_pkg;
  typedef logic [4:0] svac_band_t;
  typedef logic [2:0] svac_code_t;
  typedef enum logic [1:0] {SV_IDLE, SV_SETTLE, SV_JUDGE} svac_state_t;
  // converter code inside the locked-with-margin window
  function automatic logic svac_margin(input svac_code_t c);
    svac_margin = (c == 3'h2) || (c == 3'h5);
  endfunction
endpackage

/* File: include/svac_srch_if.sv */
// link between the register side and the band search engine
`timescale 1ns/1ps
interface svac_srch_if;
  logic                start;
  svac_pkg::svac_band_t first_band;
  svac_pkg::svac_code_t code;
  svac_pkg::svac_band_t band;
  logic                busy;
  logic                done;
  logic                found;
  modport ctrl   (output start, first_band, code, input band, busy, done, found);
  modport engine (input start, first_band, code, output band, busy, done, found);
endinterface

/* File: verif/svac_vco_model.sv */
// tune pin model: converter code seen for the oscillator band in use
`timescale 1ns/1ps
module svac_vco_model (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire svac_pkg::svac_band_t band,
  input  wire svac_pkg::svac_band_t target,
  input  wire svac_pkg::svac_code_t hit_code,
  output logic      [2:0]           code
);
  logic wobble;
  // off-target bands other than the one below the target flip between both unlocked codes, no stale value
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wobble <= 1'b0;
    end else begin
      wobble <= ~wobble;
    end
  end
  // target band shows the commanded code, the band below it only locks
  always_comb begin
    if (band == target) begin
      code = hit_code;
    end else if (band + 5'h01 == target) begin
      code = 3'h1;
    end else begin
      code = wobble ? 3'h7 : 3'h0;
    end
  end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the synthesizer control over its register bus
`timescale 1ns/1ps
`include "svac_map.svh"
module testbench;
  logic                 mclk, nrst, psel, penable, pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd_v;
  logic                 pready, pslverr, err_v, ok, tune_converter_on;
  logic [2:0]           tune_code_in;
  logic [4:0]           band_active, ref_divider;
  logic [14:0]          n_divider;
  logic [19:0]          f_divider;
  logic                 lo_divide_select, pump_current_auto, signal_path_on;
  logic [1:0]           pump_current_level;
  logic [3:0]           baseband_gain_db;
  svac_pkg::svac_band_t target;
  svac_pkg::svac_code_t hit_code;
  int                   err_total, checks;

  svac_top dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tune_code_in(tune_code_in), .tune_converter_on(tune_converter_on),
    .band_active(band_active), .n_divider(n_divider), .f_divider(f_divider),
    .ref_divider(ref_divider), .lo_divide_select(lo_divide_select),
    .pump_current_auto(pump_current_auto), .pump_current_level(pump_current_level),
    .baseband_gain_db(baseband_gain_db), .signal_path_on(signal_path_on));
  svac_vco_model vco (.mclk(mclk), .nrst(nrst), .band(band_active), .target(target),
    .hit_code(hit_code), .code(tune_code_in));

  // ---------------------------------------------------------------
  // bus cycles and comparison
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // setup, access until pready, release with one idle cycle
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // no wait-state count assumed; only the watchdog ends a stuck access
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, rd_v, err_v);
    chk({31'h0, err_v}, 32'h0);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, rd_v, err_v);
    chk(rd_v, exp);
  endtask
  task automatic conclude;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog, test sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // whole run is near 50k cycles, limit at 80k cycles
  initial begin
    #400000;
    err_total++;
    conclude();
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    target = 5'h1F;
    hit_code = 3'h0;
    err_total = 0;
    checks = 0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rdc(`SVAC_IDX_CTRL, 32'h0);
    rdc(`SVAC_IDX_REFDIV, 32'h1);
    rdc(`SVAC_IDX_STAT1, 32'h2);
    rdc(`SVAC_IDX_STAT2, 32'h0);
    $display("test reset_values done");
    repeat (20000) @(posedge mclk);
    // divider example: n 80, f 0x5ED09, ref 1, fraction lsb last
    wr(`SVAC_IDX_CTRL, 32'h0F);
    chk({28'h0, baseband_gain_db}, 32'hF);
    wr(`SVAC_IDX_NHI, 32'h00);
    wr(`SVAC_IDX_NLO, 32'h50);
    wr(`SVAC_IDX_FHI, 32'h05);
    wr(`SVAC_IDX_FMID, 32'hED);
    wr(`SVAC_IDX_REFDIV, 32'h01);
    wr(`SVAC_IDX_PUMP, 32'h0B);
    wr(`SVAC_IDX_OSC, 32'h38);
    wr(`SVAC_IDX_FLSB, 32'h09);
    chk({17'h0, n_divider}, 32'h50);
    chk({12'h0, f_divider}, 32'h5ED09);
    chk({27'h0, ref_divider}, 32'h1);
    chk({28'h0, lo_divide_select, pump_current_auto, pump_current_level}, 32'hB);
    chk({27'h0, band_active}, 32'h7);
    rdc(`SVAC_IDX_STAT1, 32'h2);
    rdc(`SVAC_IDX_STAT2, 32'h38);
    apb(1'b0, 6'h09, 32'h0, rd_v, err_v);
    chk({31'h0, err_v}, 32'h1);
    apb(1'b1, `SVAC_IDX_STAT1, 32'h0, rd_v, err_v);
    chk({31'h0, err_v}, 32'h1);
    rdc(`SVAC_IDX_STAT1, 32'h2);
    $display("test dividers done");
    // converter: latch ignored while off, then every code captured
    target <= 5'h05;
    hit_code <= 3'h5;
    wr(`SVAC_IDX_OSC, 32'h29);
    rdc(`SVAC_IDX_STAT2, 32'h28);
    wr(`SVAC_IDX_OSC, 32'h2A);
    chk({31'h0, tune_converter_on}, 32'h1);
    for (int c = 0; c < 8; c++) begin
      hit_code <= c[2:0];
      wr(`SVAC_IDX_OSC, 32'h2B);
      rdc(`SVAC_IDX_STAT2, {24'h0, 5'h05, c[2:0]});
    end
    $display("test converter done");
    // search from band 7, target 9 shows each code, band 8 only locks
    target <= 5'h09;
    ok = 1'b0;
    for (int c = 0; c < 8; c++) begin
      hit_code <= c[2:0];
      wr(`SVAC_IDX_OSC, 32'h3E);
      wr(`SVAC_IDX_FLSB, 32'h09);
      // success flag keeps the previous search's outcome while running
      rdc(`SVAC_IDX_STAT1, {31'h0, ok});
      ok = (c == 2) || (c == 5);
      chk({27'h0, band_active}, 32'h7);
      rd_v = 32'h0;
      // a search that never ends is caught by the watchdog
      while (rd_v[1] !== 1'b1) begin
        apb(1'b0, `SVAC_IDX_STAT1, 32'h0, rd_v, err_v);
      end
      chk(rd_v, ok ? 32'h3 : 32'h2);
      rdc(`SVAC_IDX_STAT2, {24'h0, (ok ? 5'h09 : 5'h07), 3'h7});
    end
    $display("test search done");
    wr(`SVAC_IDX_CTRL, 32'h85);
    chk({31'h0, signal_path_on}, 32'h0);
    wr(`SVAC_IDX_CTRL, 32'h05);
    chk({31'h0, signal_path_on}, 32'h1);
    chk({28'h0, baseband_gain_db}, 32'h5);
    chk({17'h0, n_divider}, 32'h50);
    rdc(`SVAC_IDX_FMID, 32'hED);
    $display("test standby done");
    conclude();
  end
endmodule
